// ===== core/pmad_pkg.sv
// constants for the activity event and resource decode block
// Operation
// [RQ1] pm port read raises smi when enabled
// [RQ2] video enable gates device 11 reload event
// [RQ3] slice qualifies when phases exceed threshold
// [RQ4] video event when qualifying slices exceed threshold
// [RQ5] unmasked irq nmi init reload global timer
// [RQ6] rtc irq gives fast burst or break
// [RQ7] power inputs give fast burst or break
// [RQ8] software writes zero to bit three
// [RQ9] keyboard or mouse irq reloads global timer
// [RQ10] unmasked irq nmi init give burst event
// [RQ11] unmasked timer irq gives burst event
// [RQ12] device 8 io forwarded with monitor enable
// [RQ13] device 13 ranges claimed and forwarded
// [RQ14] device 12 ranges claimed and forwarded
// [RQ15] decode keyboard ports 60h and 64h
// [RQ16] a b segments monitored, never claimed
// [RQ17] vga io monitored, never claimed
// [RQ18] enabled sound ranges claimed and forwarded
// [RQ19] frame buffer window monitored, never claimed
// [RQ20] mask bits ignore address bits 21:20
// [RQ21] base compares address bits 31:20
// [RQ22] window hit when unmasked bits match
// [RQ23] reserved activity bits read zero
package pmad_pkg;
	localparam logic [7:0]  OFS_ACTIVITY = 8'h58;
	localparam logic [7:0]  OFS_RESOURCE = 8'h5C;
	localparam logic [31:0] RST_ACTIVITY = 32'h0000_0000;
	localparam logic [31:0] RST_RESOURCE = 32'h0000_0000;
	localparam logic [31:0] ACT_WMASK    = 32'h03FF_FF7F;
	localparam int B_PORT_SMI   = 25;
	localparam int B_VIDEO      = 24;
	localparam int B_PCT_LO     = 16;
	localparam int B_PHASE_LO   = 8;
	localparam int B_IRQ_GRLD   = 6;
	localparam int B_RTC_EVT    = 5;
	localparam int B_PWR_EVT    = 4;
	localparam int B_KBD_GRLD   = 2;
	localparam int B_IRQ_EVT    = 1;
	localparam int B_TMR_EVT    = 0;
	localparam int B_DEV8_FWD   = 31;
	localparam int B_DEV13_FWD  = 30;
	localparam int B_DEV12_FWD  = 29;
	localparam int B_KBD_DEC    = 28;
	localparam int B_AB_DEC     = 27;
	localparam int B_VGA_DEC    = 26;
	localparam int B_SND_FWD    = 25;
	localparam int B_FB_DEC     = 24;
	localparam int B_FB_MASK_LO = 22;
	localparam int B_FB_BASE_LO = 10;
	localparam logic [15:0] IRQ_GROUP = 16'hFEFA;
	localparam int IRQ_TMR   = 0;
	localparam int IRQ_KBD   = 1;
	localparam int IRQ_RTC   = 8;
	localparam int IRQ_MOUSE = 12;
	localparam logic [31:0] KBD_PORT_A = 32'h0000_0060;
	localparam logic [31:0] KBD_PORT_B = 32'h0000_0064;
	localparam logic [15:0] VGA_LO     = 16'h03B0;
	localparam logic [15:0] VGA_HI     = 16'h03DF;
	localparam logic [14:0] AB_SEG     = 15'h0005;
	localparam int SLICE_BITS  = 8;
	localparam int WINDOW_BITS = 8;
endpackage

// ===== core/pmad.sv
// activity event enables, video utilisation detect and resource decode
`timescale 1ns/1ps
module pmad_core
	import pmad_pkg::*;
#(
	parameter int SLICE_W  = SLICE_BITS,
	parameter int WINDOW_W = WINDOW_BITS
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	input  wire logic        pm_control_port_read,
	input  wire logic        smi_global_enable,
	input  wire logic [15:0] irq_level,
	input  wire logic [15:0] irq_mask,
	input  wire logic        nmi,
	input  wire logic        init,
	input  wire logic        system_mgmt_interrupt_n,
	input  wire logic        general_input_1_n,
	input  wire logic        power_button_n,
	input  wire logic        lid_switch,
	input  wire logic        pci_data_phase,
	input  wire logic        pci_valid,
	input  wire logic        pci_is_io,
	input  wire logic        pci_is_mem,
	input  wire logic [31:0] pci_addr,
	input  wire logic        parallel_port_monitor_enable,
	input  wire logic        dev8_io_hit,
	input  wire logic        dev13_memory_enable,
	input  wire logic        dev13_io_enable,
	input  wire logic        dev13_mem_hit,
	input  wire logic        dev13_io_hit,
	input  wire logic        dev12_memory_enable,
	input  wire logic        dev12_io_enable,
	input  wire logic        dev12_mem_hit,
	input  wire logic        dev12_io_hit,
	input  wire logic        kbd_forward_enable,
	input  wire logic        sound_decode_enable,
	input  wire logic        sound_range_hit,
	output logic             smi_request,
	output logic             global_reload,
	output logic             fast_burst_event,
	output logic             burst_event,
	output logic             video_event,
	output logic             pci_claim,
	output logic             kbd_port_hit,
	output logic             vga_io_hit,
	output logic             ab_segment_hit,
	output logic             fb_window_hit
);
	logic [31:0] device_activity_events;
	logic [31:0] device_resource_decode;
	logic [15:0] irq_prev;
	logic        nmi_prev;
	logic        init_prev;
	logic [3:0]  pwr_prev;
	logic [SLICE_W-1:0]  slice_clk;
	logic [SLICE_W:0]    phase_cnt;
	logic [WINDOW_W-1:0] window_slice;
	logic [WINDOW_W:0]   qual_cnt;
	logic [31:0] next_activity;
	logic [31:0] next_resource;
	logic        wr_act;
	logic        wr_res;
	logic [15:0] irq_rise;
	logic [15:0] irq_live;
	logic        grp_rise;
	logic [3:0]  pwr_now;
	logic        pwr_rise;
	logic        slice_end;
	logic        window_end;
	logic [SLICE_W:0]  phase_total;
	logic              slice_qual;
	logic [WINDOW_W:0] qual_total;
	logic [11:0] fb_base;
	logic [11:0] fb_keep;
	logic        io_ok;
	logic        mem_ok;
	logic        hit_kbd;
	logic        hit_vga;
	logic        hit_ab;
	logic        hit_fb;
	logic        fwd;
	logic [7:0]  phase_thr;
	logic [7:0]  pct_thr;

	assign wr_act = cfg_wr && cfg_addr == OFS_ACTIVITY;
	assign wr_res = cfg_wr && cfg_addr == OFS_RESOURCE;

	always_comb begin
		next_activity = device_activity_events;
		next_resource = device_resource_decode;
		for (int i = 0; i < 4; i++) begin
			if (cfg_be[i]) begin
				next_activity[i*8 +: 8] = cfg_wdata[i*8 +: 8];
				next_resource[i*8 +: 8] = cfg_wdata[i*8 +: 8];
			end
		end
		// reserved bits held at zero on every write; see [RQ23]
		next_activity = next_activity & ACT_WMASK;
	end

	// bit three is stored as written; software must keep it zero, see [RQ8]
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			device_activity_events <= RST_ACTIVITY;
		end else if (wr_act) begin
			device_activity_events <= next_activity;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			device_resource_decode <= RST_RESOURCE;
		end else if (wr_res) begin
			device_resource_decode <= next_resource;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_rd) begin
			unique case (cfg_addr)
				OFS_ACTIVITY: cfg_rdata <= device_activity_events;
				OFS_RESOURCE: cfg_rdata <= device_resource_decode;
				default:      cfg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// edges taken against the raw level: unmasking a held line is no event
	assign pwr_now  = {~system_mgmt_interrupt_n, ~general_input_1_n,
		~power_button_n, lid_switch};
	assign irq_live = irq_level & ~irq_mask;
	assign irq_rise = irq_live & ~irq_prev;
	assign grp_rise = |(irq_rise & IRQ_GROUP) || (nmi && !nmi_prev) ||
		(init && !init_prev);
	assign pwr_rise = |(pwr_now & ~pwr_prev);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_prev  <= 16'h0000;
			nmi_prev  <= 1'b0;
			init_prev <= 1'b0;
			pwr_prev  <= 4'h0;
		end else begin
			irq_prev  <= irq_level;
			nmi_prev  <= nmi;
			init_prev <= init;
			pwr_prev  <= pwr_now;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			smi_request <= 1'b0;
		end else begin
			smi_request <= pm_control_port_read && smi_global_enable &&
				device_activity_events[B_PORT_SMI]; // see [RQ1]
		end
	end

	// kbd and mouse lines use the raw level, mask does not apply
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			global_reload <= 1'b0;
		end else begin
			global_reload <= (device_activity_events[B_IRQ_GRLD] &&
				grp_rise) || // see [RQ5]
				(device_activity_events[B_KBD_GRLD] &&
				(irq_level[IRQ_KBD] && !irq_prev[IRQ_KBD] ||
				irq_level[IRQ_MOUSE] && !irq_prev[IRQ_MOUSE])); // see [RQ9]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fast_burst_event <= 1'b0;
		end else begin
			fast_burst_event <= (device_activity_events[B_RTC_EVT] &&
				irq_rise[IRQ_RTC]) || // see [RQ6]
				(device_activity_events[B_PWR_EVT] && pwr_rise); // see [RQ7]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			burst_event <= 1'b0;
		end else begin
			burst_event <= (device_activity_events[B_IRQ_EVT] &&
				grp_rise) || // see [RQ10]
				(device_activity_events[B_TMR_EVT] &&
				irq_rise[IRQ_TMR]); // see [RQ11]
		end
	end

	// video utilisation: phases per slice, qualifying slices per window
	assign phase_thr   = device_activity_events[B_PHASE_LO +: 8];
	assign pct_thr     = device_activity_events[B_PCT_LO +: 8];
	assign slice_end   = &slice_clk;
	assign window_end  = slice_end && &window_slice;
	assign phase_total = phase_cnt + {{SLICE_W{1'b0}}, pci_data_phase};
	assign slice_qual  = 32'(phase_total) > 32'(phase_thr);
	assign qual_total  = qual_cnt + {{WINDOW_W{1'b0}}, slice_qual};

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			slice_clk <= '0;
			phase_cnt <= '0;
		end else begin
			slice_clk <= slice_clk + 1'b1;
			// count cannot pass 2^SLICE_W, so no saturation is needed
			phase_cnt <= slice_end ? '0 : phase_total; // see [RQ3]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			window_slice <= '0;
			qual_cnt     <= '0;
		end else if (slice_end) begin
			window_slice <= window_slice + 1'b1;
			qual_cnt     <= window_end ? '0 : qual_total; // see [RQ4]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			video_event <= 1'b0;
		end else begin
			video_event <= window_end && device_activity_events[B_VIDEO] &&
				32'(qual_total) > 32'(pct_thr); // see [RQ2]
		end
	end

	// resource decode
	assign io_ok   = pci_valid && pci_is_io;
	assign mem_ok  = pci_valid && pci_is_mem;
	assign fb_base = device_resource_decode[B_FB_BASE_LO +: 12];
	assign fb_keep = {10'h3FF,
		~device_resource_decode[B_FB_MASK_LO +: 2]}; // see [RQ20]
	assign hit_fb  = mem_ok && device_resource_decode[B_FB_DEC] &&
		((pci_addr[31:20] ^ fb_base) & fb_keep) == 12'h000; // see [RQ21] [RQ22]
	assign hit_kbd = io_ok && device_resource_decode[B_KBD_DEC] &&
		(pci_addr == KBD_PORT_A || pci_addr == KBD_PORT_B); // see [RQ15]
	assign hit_vga = io_ok && device_resource_decode[B_VGA_DEC] &&
		pci_addr[31:16] == 16'h0000 &&
		pci_addr[15:0] >= VGA_LO && pci_addr[15:0] <= VGA_HI; // see [RQ17]
	assign hit_ab  = mem_ok && device_resource_decode[B_AB_DEC] &&
		pci_addr[31:17] == AB_SEG; // see [RQ16]

	// monitor-only decodes never enter the claim term; see [RQ16] [RQ17] [RQ19]
	assign fwd =
		(io_ok && device_resource_decode[B_DEV8_FWD] &&
		parallel_port_monitor_enable && dev8_io_hit) || // see [RQ12]
		(device_resource_decode[B_DEV13_FWD] &&
		(mem_ok && dev13_memory_enable && dev13_mem_hit ||
		io_ok && dev13_io_enable && dev13_io_hit)) || // see [RQ13]
		(device_resource_decode[B_DEV12_FWD] &&
		(mem_ok && dev12_memory_enable && dev12_mem_hit ||
		io_ok && dev12_io_enable && dev12_io_hit)) || // see [RQ14]
		(hit_kbd && kbd_forward_enable) ||
		(io_ok && device_resource_decode[B_SND_FWD] &&
		sound_decode_enable && sound_range_hit); // see [RQ18]

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pci_claim      <= 1'b0;
			kbd_port_hit   <= 1'b0;
			vga_io_hit     <= 1'b0;
			ab_segment_hit <= 1'b0;
			fb_window_hit  <= 1'b0;
		end else begin
			pci_claim      <= fwd;
			kbd_port_hit   <= hit_kbd;
			vga_io_hit     <= hit_vga;
			ab_segment_hit <= hit_ab;
			fb_window_hit  <= hit_fb;
		end
	end

	// checks
	sequence s_port_read;
		pm_control_port_read && smi_global_enable &&
			device_activity_events[B_PORT_SMI];
	endsequence
	property p_port_smi;
		@(posedge clk_sys) disable iff (reset)
		s_port_read |=> smi_request;
	endproperty
	a_port_smi: assert property (p_port_smi) // see [RQ1]
		else $error("port read did not raise smi");

	property p_smi_cause;
		@(posedge clk_sys) disable iff (reset)
		smi_request |-> $past(pm_control_port_read);
	endproperty
	a_smi_cause: assert property (p_smi_cause) // see [RQ1]
		else $error("smi without port read");

	property p_video_gate;
		@(posedge clk_sys) disable iff (reset)
		!device_activity_events[B_VIDEO] |=> !video_event;
	endproperty
	a_video_gate: assert property (p_video_gate) // see [RQ2]
		else $error("video event while disabled");

	property p_video_window;
		@(posedge clk_sys) disable iff (reset)
		video_event |-> $past(window_end);
	endproperty
	a_video_window: assert property (p_video_window) // see [RQ4]
		else $error("video event off window end");

	property p_slice_clear;
		@(posedge clk_sys) disable iff (reset)
		slice_end |=> phase_cnt == '0 && slice_clk == '0;
	endproperty
	a_slice_clear: assert property (p_slice_clear) // see [RQ3]
		else $error("slice counters not cleared");

	sequence s_timer_rise;
		device_activity_events[B_TMR_EVT] && irq_rise[IRQ_TMR];
	endsequence
	property p_timer_burst;
		@(posedge clk_sys) disable iff (reset)
		s_timer_rise |=> burst_event;
	endproperty
	a_timer_burst: assert property (p_timer_burst) // see [RQ11]
		else $error("timer irq gave no burst");

	property p_rtc_fast;
		@(posedge clk_sys) disable iff (reset)
		device_activity_events[B_RTC_EVT] && irq_rise[IRQ_RTC]
			|=> fast_burst_event;
	endproperty
	a_rtc_fast: assert property (p_rtc_fast) // see [RQ6]
		else $error("rtc irq gave no fast burst");

	property p_reserved_zero;
		@(posedge clk_sys) disable iff (reset)
		(device_activity_events & ~ACT_WMASK) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // see [RQ23]
		else $error("reserved activity bit set");

	property p_ab_noclaim;
		@(posedge clk_sys) disable iff (reset)
		hit_ab && !dev13_mem_hit && !dev12_mem_hit |=> !pci_claim;
	endproperty
	a_ab_noclaim: assert property (p_ab_noclaim) // see [RQ16]
		else $error("a b segment claimed");

	property p_fb_hit;
		@(posedge clk_sys) disable iff (reset)
		mem_ok && device_resource_decode[B_FB_DEC] &&
			pci_addr[31:22] == fb_base[11:2] &&
			device_resource_decode[B_FB_MASK_LO +: 2] == 2'h3
			|=> fb_window_hit;
	endproperty
	a_fb_hit: assert property (p_fb_hit) // see [RQ20] [RQ22]
		else $error("masked window missed");
endmodule // pmad_core

// ===== tb/pmad_pci_init.sv
// pci initiator model driving access and data phase inputs
`timescale 1ns/1ps
module pmad_pci_init (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        go,
	input  wire logic        io,
	input  wire logic [31:0] addr,
	output logic             pci_valid,
	output logic             pci_is_io,
	output logic             pci_is_mem,
	output logic             pci_data_phase,
	output logic      [31:0] pci_addr
);
	// released address toggles, so a stale match never lingers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pci_valid      <= 1'b0;
			pci_is_io      <= 1'b0;
			pci_is_mem     <= 1'b0;
			pci_data_phase <= 1'b0;
			pci_addr       <= 32'hFFFF_FFFF;
		end else begin
			pci_valid      <= go;
			pci_is_io      <= go & io;
			pci_is_mem     <= go & ~io;
			pci_data_phase <= go;
			pci_addr       <= go ? addr : ~pci_addr;
		end
	end
endmodule // pmad_pci_init

// ===== tb/tb_top.sv
// self-checking bench for the activity event and resource decode block
`timescale 1ns/1ps
module tb_top;
	import pmad_pkg::*;
	logic        clk_sys, reset, cfg_wr, cfg_rd, go, io;
	logic        pm_control_port_read, smi_global_enable;
	logic        pci_valid, pci_is_io, pci_is_mem, pci_data_phase;
	logic        smi_request, global_reload, fast_burst_event, burst_event;
	logic        video_event, pci_claim, kbd_port_hit, vga_io_hit;
	logic        ab_segment_hit, fb_window_hit;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [2:0]  sel;
	logic [2:0]  ev;
	logic [4:0]  dv;
	logic [6:0]  en;
	logic [5:0]  hit;
	logic [12:0] e;
	logic [21:0] src;
	logic [15:0] irq_mask;
	logic [31:0] cfg_wdata, cfg_rdata, addr, pci_addr, a, rv, act, res;
	logic [31:0] rnd_s, wd;
	logic [31:0] vcfg [4] = '{32'h0107_0700, 32'h0100_0800,
		32'h0108_0000, 32'h0007_0700};
	int          vexp [4] = '{4, 0, 0, 0};
	int          errors, cmp_count, i, k, n;

	pmad_core #(.SLICE_W(3), .WINDOW_W(3)) uut (
		.clk_sys, .reset, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
		.cfg_rdata, .pm_control_port_read, .smi_global_enable,
		.irq_level(src[15:0]), .irq_mask, .nmi(src[16]), .init(src[17]),
		.system_mgmt_interrupt_n(~src[18]), .general_input_1_n(~src[19]),
		.power_button_n(~src[20]), .lid_switch(src[21]),
		.pci_data_phase, .pci_valid, .pci_is_io, .pci_is_mem, .pci_addr,
		.parallel_port_monitor_enable(en[6]), .dev8_io_hit(hit[5]),
		.dev13_memory_enable(en[5]), .dev13_io_enable(en[4]),
		.dev13_mem_hit(hit[4]), .dev13_io_hit(hit[3]),
		.dev12_memory_enable(en[3]), .dev12_io_enable(en[2]),
		.dev12_mem_hit(hit[2]), .dev12_io_hit(hit[1]),
		.kbd_forward_enable(en[1]), .sound_decode_enable(en[0]),
		.sound_range_hit(hit[0]), .smi_request, .global_reload,
		.fast_burst_event, .burst_event, .video_event, .pci_claim,
		.kbd_port_hit, .vga_io_hit, .ab_segment_hit, .fb_window_hit
	);

	pmad_pci_init partner (
		.clk_sys, .reset, .go, .io, .addr, .pci_valid, .pci_is_io,
		.pci_is_mem, .pci_data_phase, .pci_addr
	);

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, d,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			if (be[b]) o[8*b +: 8] = d[8*b +: 8];
		end
		return o;
	endfunction

	// {global, fast, burst}; keyboard and mouse ignore the mask
	function automatic logic [2:0] exp_ev(input logic [31:0] c,
		input logic [21:0] s, input logic [15:0] m);
		logic [15:0] u;
		logic        g;
		u = s[15:0] & ~m;
		g = |(u & IRQ_GROUP) | s[16] | s[17];
		return {c[6] & g | c[2] & (s[1] | s[12]),
			c[5] & u[8] | c[4] & |s[21:18], c[1] & g | c[0] & u[0]};
	endfunction

	// {claim, kbd, vga, ab, fb}
	function automatic logic [4:0] exp_dec(input logic [31:0] r, x,
		input logic o, input logic [12:0] f);
		logic kb, fb;
		kb = o & (x == KBD_PORT_A || x == KBD_PORT_B);
		fb = ~o & (((x[31:20] ^ r[21:10]) & {10'h3FF, ~r[23:22]}) == 12'h0);
		return {r[31] & f[12] & f[5] | r[30] & (f[11] & f[4] | f[10] & f[3])
			| r[29] & (f[9] & f[2] | f[8] & f[1]) | r[25] & f[6] & f[0]
			| r[28] & f[7] & kb, r[28] & kb,
			r[26] & o & x >= {16'h0, VGA_LO} & x <= {16'h0, VGA_HI},
			r[27] & ~o & (x[31:17] == AB_SEG), r[24] & fb};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_addr <= ad;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad);
		@(posedge clk_sys);
		cfg_rd <= 1'b1;
		cfg_addr <= ad;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1 rv = cfg_rdata;
	endtask

	initial begin
		#400000;
		errors++;
		give_verdict;
	end

	initial begin
		{cfg_wr, cfg_rd, go, io, pm_control_port_read} = '0;
		{smi_global_enable, cfg_addr, cfg_be, en, hit, src} = '0;
		{irq_mask, cfg_wdata, addr} = '0;
		errors = 0;
		cmp_count = 0;
		rnd_s = 32'h1E9B;
		reset = 1'b1;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h60);
		chk(rv, 32'h0);
		rd(OFS_ACTIVITY);
		chk(rv, RST_ACTIVITY);
		act = RST_ACTIVITY;
		res = RST_RESOURCE;
		for (i = 0; i < 12; i++) begin
			rnd_s = xs(rnd_s);
			wd = (i == 0) ? 32'hFFFF_FFF7 : rnd_s & 32'hFFFF_FFF7;
			rnd_s = xs(rnd_s);
			if (i == 0) rnd_s[7:0] = 8'hFF;
			wr(OFS_ACTIVITY, rnd_s[3:0], wd);
			act = merge(act, wd, rnd_s[3:0]) & ACT_WMASK;
			wr(OFS_RESOURCE, rnd_s[7:4], ~wd);
			res = merge(res, ~wd, rnd_s[7:4]);
			wr(8'h60, 4'hF, wd);
			rd(OFS_ACTIVITY);
			chk(rv, act);
			rd(OFS_RESOURCE);
			chk(rv, res);
			rd(8'h60);
			chk(rv, 32'h0);
		end
		for (i = 0; i < 4; i++) begin
			wr(OFS_ACTIVITY, 4'hF, {6'h0, i[0], 25'h0});
			@(posedge clk_sys);
			smi_global_enable <= i[1];
			pm_control_port_read <= 1'b1;
			@(posedge clk_sys);
			pm_control_port_read <= 1'b0;
			#1 chk(smi_request, i[0] & i[1]);
		end
		for (i = 0; i < 60; i++) begin
			rnd_s = xs(rnd_s);
			act = rnd_s & 32'h0000_0077;
			wr(OFS_ACTIVITY, 4'hF, act);
			irq_mask <= rnd_s[31:16];
			k = rnd_s[15:8] % 22;
			@(posedge clk_sys);
			src <= 22'h1 << k;
			@(posedge clk_sys);
			#1 ev = exp_ev(act, 22'h1 << k, irq_mask);
			chk(global_reload, ev[2]);
			chk(fast_burst_event, ev[1]);
			chk(burst_event, ev[0]);
			@(posedge clk_sys);
			#1 ev = {global_reload, fast_burst_event, burst_event};
			chk(ev, 3'h0);
			@(posedge clk_sys);
			src <= 22'h0;
		end
		for (i = 0; i < 80; i++) begin
			rnd_s = xs(rnd_s);
			res = rnd_s;
			wr(OFS_RESOURCE, 4'hF, res);
			rnd_s = xs(rnd_s);
			sel = rnd_s[2:0];
			case (sel)
				3'h0: a = {res[21:10] ^ {10'h0, rnd_s[4:3]}, rnd_s[24:5]};
				3'h1: a = {AB_SEG, rnd_s[31:15]};
				3'h2: a = 32'h3AF + rnd_s[31:8] % 32'h32;
				3'h3: a = 32'h60 + rnd_s[31:8] % 32'h6;
				default: a = xs(rnd_s);
			endcase
			rnd_s = xs(rnd_s);
			e = rnd_s[12:0];
			e[5:0] = e[5:0] & (sel[1] ? 6'h2B : 6'h14);
			@(posedge clk_sys);
			go <= 1'b1;
			io <= sel[1];
			addr <= a;
			en <= e[12:6];
			@(posedge clk_sys);
			go <= 1'b0;
			hit <= e[5:0];
			@(posedge clk_sys);
			hit <= 6'h0;
			#1 dv = exp_dec(res, a, sel[1], e);
			chk(pci_claim, dv[4]);
			chk(kbd_port_hit, dv[3]);
			chk(vga_io_hit, dv[2]);
			chk(ab_segment_hit, dv[1]);
			chk(fb_window_hit, dv[0]);
		end
		// continuous phases: every slice holds 8, so thresholds 7 and 8 split
		for (i = 0; i < 4; i++) begin
			wr(OFS_ACTIVITY, 4'hF, vcfg[i]);
			@(posedge clk_sys);
			go <= 1'b1;
			io <= 1'b1;
			addr <= 32'h0;
			n = 0;
			for (k = 0; k < 336; k++) begin
				@(posedge clk_sys);
				#1 if (k >= 80 && video_event === 1'b1) n++;
			end
			@(posedge clk_sys);
			go <= 1'b0;
			chk(n, vexp[i]);
		end
		give_verdict;
	end
endmodule // tb_top
